// >>> verilog/sswd_supervisor.sv
// Supply switchover, reset generation, watchdog and two-wire slave framing
`timescale 1ns/1ps
module sswd_supervisor
  import sswd_pkg::*;
#(
  parameter int RESET_TICKS_P = RESET_TICKS
)(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       oscTick,
  input  sswd_cmp_t       cmpIn,
  input  wire logic       supplySwitchSelect,
  input  wire logic       wdogPeriodHi,
  input  wire logic       wdogPeriodLo,
  input  wire logic       nvWriteBusy,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  input  wire logic [7:0] txData,
  output logic            reset_n,
  output logic            onBackup,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic [7:0]      rxData,
  output logic            rxValid,
  output logic            addrMatch,
  output logic            ctrlSelect,
  output logic            readReq,
  output logic            busStop,
  output logic            abortWrite
);
  // Interval length for each watchdog period code
  function automatic logic [TICK_W-1:0] wdogLoad(input logic [1:0] sel);
    case (sel)
      WDOG_SHORT: wdogLoad = TICK_W'(WDOG_SHORT_TICKS);
      WDOG_MID:   wdogLoad = TICK_W'(WDOG_MID_TICKS);
      WDOG_LONG:  wdogLoad = TICK_W'(WDOG_LONG_TICKS);
      default:    wdogLoad = '0;
    endcase
  endfunction

  sswd_bus_t  busEv;
  sswd_cmp_t  cmp1_q, cmp2_q;
  logic [1:0] wdSel;

  sswd_bus_detect u_detect (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .busEv   (busEv)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp1_q <= '0;
      cmp2_q <= 5'h01;
    end else if (clkEn) begin
      cmp1_q <= cmpIn;
      cmp2_q <= cmp1_q;
    end
  end

  assign wdSel = {wdogPeriodHi, wdogPeriodLo};

  // Supply selection and reset/watchdog timing
  logic              backup_q,   backup_d;
  logic              rstOut_q,   rstOut_d;
  logic [TICK_W-1:0] rstCnt_q,   rstCnt_d;
  logic              wdPulse_q,  wdPulse_d;
  logic [TICK_W-1:0] wdCnt_q,    wdCnt_d;
  logic [1:0]        wdSelOld_q, wdSelOld_d;
  logic              uvHold_q,   uvHold_d;

  always_comb begin
    backup_d   = backup_q;
    rstOut_d   = rstOut_q;
    rstCnt_d   = rstCnt_q;
    wdPulse_d  = wdPulse_q;
    wdCnt_d    = wdCnt_q;
    wdSelOld_d = wdSel;
    uvHold_d   = uvHold_q;
    if (!backup_q) begin
      if (supplySwitchSelect) begin
        if (cmp2_q.mainBelowBackupLo) backup_d = 1'b1;
      end else if (cmp2_q.mainBelowBackupLo && cmp2_q.mainBelowSwitchover) begin
        backup_d = 1'b1;
      end
    end else begin
      if (supplySwitchSelect) begin
        if (cmp2_q.mainAboveBackupHi) backup_d = 1'b0;
      end else if (cmp2_q.mainAboveBackupHi || cmp2_q.mainAboveSwitchHi) begin
        backup_d = 1'b0;
      end
    end
    // Latch that reset came from low supply while on backup
    if (backup_q && cmp2_q.mainBelowReset) uvHold_d = 1'b1;
    else if (!backup_q) uvHold_d = 1'b0;
    if (cmp2_q.mainBelowReset || uvHold_q) begin
      rstOut_d  = 1'b1;
      rstCnt_d  = TICK_W'(RESET_TICKS_P);
      wdPulse_d = 1'b0;
      wdCnt_d   = wdogLoad(wdSel);
    end else if (rstOut_q) begin
      if (oscTick) begin
        if (rstCnt_q <= TICK_W'(1)) begin
          rstOut_d  = 1'b0;
          wdPulse_d = 1'b0;
          wdCnt_d   = wdogLoad(wdSel);
        end else begin
          rstCnt_d = rstCnt_q - TICK_W'(1);
        end
      end
    end else if (backup_q || wdSel == WDOG_OFF) begin
      wdCnt_d = wdogLoad(wdSel);
    end else if (busEv.start || wdSel != wdSelOld_q) begin
      wdCnt_d = wdogLoad(wdSel);
    end else if (oscTick) begin
      if (wdCnt_q <= TICK_W'(1)) begin
        rstOut_d  = 1'b1;
        wdPulse_d = 1'b1;
        rstCnt_d  = TICK_W'(RESET_TICKS_P);
      end else begin
        wdCnt_d = wdCnt_q - TICK_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      backup_q   <= 1'b0;
      rstOut_q   <= 1'b1;
      rstCnt_q   <= TICK_W'(RESET_TICKS_P);
      wdPulse_q  <= 1'b0;
      wdCnt_q    <= '0;
      wdSelOld_q <= WDOG_OFF;
      uvHold_q   <= 1'b0;
    end else if (clkEn) begin
      backup_q   <= backup_d;
      rstOut_q   <= rstOut_d;
      rstCnt_q   <= rstCnt_d;
      wdPulse_q  <= wdPulse_d;
      wdCnt_q    <= wdCnt_d;
      wdSelOld_q <= wdSelOld_d;
      uvHold_q   <= uvHold_d;
    end
  end

  // Slave framing; held off while a supply reset is running
  logic        busLock;
  sswd_slave_t st_q,    st_d;
  logic [3:0]  bitCnt_q, bitCnt_d;
  logic [7:0]  shift_q, shift_d;
  logic        sdaO_q,  sdaO_d;
  logic        sdaE_q,  sdaE_d;
  logic [7:0]  rxD_q,   rxD_d;
  logic        rxV_q,   rxV_d;
  logic        match_q, match_d;
  logic        ctrl_q,  ctrl_d;
  logic        rdReq_q, rdReq_d;
  logic        stop_q,  stop_d;
  logic        abort_q, abort_d;
  logic        isRead_q, isRead_d;

  assign busLock = rstOut_q && !wdPulse_q;

  always_comb begin
    st_d     = st_q;
    bitCnt_d = bitCnt_q;
    shift_d  = shift_q;
    sdaO_d   = 1'b1;
    sdaE_d   = sdaE_q;
    rxD_d    = rxD_q;
    rxV_d    = 1'b0;
    match_d  = match_q;
    ctrl_d   = ctrl_q;
    rdReq_d  = 1'b0;
    stop_d   = busEv.stop;
    isRead_d = isRead_q;
    // Running write cycle finishes unless main is below the reset threshold while on backup supply
    abort_d  = nvWriteBusy && backup_q && cmp2_q.mainBelowReset;
    if (busLock) begin
      st_d    = SL_IDLE;
      sdaE_d  = 1'b0;
      match_d = 1'b0;
    end else if (busEv.stop) begin
      st_d    = SL_IDLE;
      sdaE_d  = 1'b0;
      match_d = 1'b0;
    end else if (busEv.start) begin
      st_d     = SL_ADDR;
      bitCnt_d = '0;
      sdaE_d   = 1'b0;
      match_d  = 1'b0;
    end else begin
      case (st_q)
        SL_IDLE: st_d = SL_IDLE;
        SL_ADDR, SL_WRX: begin
          if (busEv.sclRise && bitCnt_q < 4'(BYTE_BITS)) begin
            shift_d  = {shift_q[6:0], busEv.sda};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (busEv.sclFall && bitCnt_q == 4'(BYTE_BITS)) begin
            if (st_q == SL_ADDR) begin
              if (shift_q[7:1] == ARRAY_ID || shift_q[7:1] == CTRL_ID) begin
                match_d  = 1'b1;
                ctrl_d   = shift_q[7:1] == CTRL_ID;
                isRead_d = shift_q[0];
                sdaE_d   = 1'b1;
                st_d     = SL_WACK;
              end else begin
                st_d = SL_IDLE;
              end
            end else begin
              rxD_d  = shift_q;
              rxV_d  = 1'b1;
              sdaE_d = 1'b1;
              st_d   = SL_WACK;
            end
          end
        end
        SL_WACK: begin
          if (busEv.sclFall) begin
            bitCnt_d = '0;
            if (isRead_q) begin
              shift_d = txData;
              rdReq_d = 1'b1;
              sdaE_d  = !txData[7];
              st_d    = SL_TX;
            end else begin
              sdaE_d = 1'b0;
              st_d   = SL_WRX;
            end
          end
        end
        SL_TX: begin
          if (busEv.sclFall) begin
            if (bitCnt_q == 4'(BYTE_BITS - 1)) begin
              sdaE_d = 1'b0;
              st_d   = SL_RACK;
            end else begin
              shift_d  = {shift_q[6:0], 1'b0};
              bitCnt_d = bitCnt_q + 4'h1;
              sdaE_d   = !shift_q[6];
            end
          end
        end
        SL_RACK: begin
          if (busEv.sclRise) begin
            if (busEv.sda) st_d = SL_IDLE;
            else st_d = SL_WACK;
          end
        end
        default: st_d = SL_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= SL_IDLE;
      bitCnt_q <= '0;
      shift_q  <= '0;
      sdaO_q   <= 1'b1;
      sdaE_q   <= 1'b0;
      rxD_q    <= '0;
      rxV_q    <= 1'b0;
      match_q  <= 1'b0;
      ctrl_q   <= 1'b0;
      rdReq_q  <= 1'b0;
      stop_q   <= 1'b0;
      abort_q  <= 1'b0;
      isRead_q <= 1'b0;
    end else if (clkEn) begin
      st_q     <= st_d;
      bitCnt_q <= bitCnt_d;
      shift_q  <= shift_d;
      sdaO_q   <= sdaO_d;
      sdaE_q   <= sdaE_d;
      rxD_q    <= rxD_d;
      rxV_q    <= rxV_d;
      match_q  <= match_d;
      ctrl_q   <= ctrl_d;
      rdReq_q  <= rdReq_d;
      stop_q   <= stop_d;
      abort_q  <= abort_d;
      isRead_q <= isRead_d;
    end
  end

  always_comb begin
    reset_n    = !rstOut_q;
    onBackup   = backup_q;
    sdaOut     = 1'b0 & sdaO_q;
    sdaOe      = sdaE_q;
    rxData     = rxD_q;
    rxValid    = rxV_q;
    addrMatch  = match_q;
    ctrlSelect = ctrl_q;
    readReq    = rdReq_q;
    busStop    = stop_q;
    abortWrite = abort_q;
  end
endmodule

// >>> verilog/sswd_pkg.sv
// Package with constants and carrier types for the supply supervisor and watchdog
package sswd_pkg;

  localparam int CLK_HZ           = 20000000;
  localparam int OSC_HZ           = 32768;
  // Ticks of the 32.768 kHz oscillator for each interval (least time rounds up)
  localparam int RESET_TIME_MS    = 250;
  localparam int WDOG_SHORT_MS    = 250;
  localparam int WDOG_MID_MS      = 750;
  localparam int WDOG_LONG_MS     = 1750;
  localparam int RESET_TICKS      = (RESET_TIME_MS * OSC_HZ + 999) / 1000;
  localparam int WDOG_SHORT_TICKS = (WDOG_SHORT_MS * OSC_HZ + 999) / 1000;
  localparam int WDOG_MID_TICKS   = (WDOG_MID_MS * OSC_HZ + 999) / 1000;
  localparam int WDOG_LONG_TICKS  = (WDOG_LONG_MS * OSC_HZ + 999) / 1000;
  localparam int TICK_W           = 16;

  localparam logic [1:0] WDOG_OFF   = 2'h3;
  localparam logic [1:0] WDOG_SHORT = 2'h2;
  localparam logic [1:0] WDOG_MID   = 2'h1;
  localparam logic [1:0] WDOG_LONG  = 2'h0;

  localparam logic [6:0] ARRAY_ID   = 7'h57;
  localparam logic [6:0] CTRL_ID    = 7'h6F;
  localparam int         BYTE_BITS  = 8;

  // Supply comparator results, all active high
  typedef struct packed {
    logic mainBelowBackupLo;   // main < backup - hysteresis
    logic mainAboveBackupHi;   // main > backup + hysteresis
    logic mainBelowSwitchover; // main < switchover threshold
    logic mainAboveSwitchHi;   // main > switchover threshold + its hysteresis
    logic mainBelowReset;      // main < reset threshold
  } sswd_cmp_t;

  // Bus events decoded from the synchronised pins
  typedef struct packed {
    logic start;
    logic stop;
    logic sclRise;
    logic sclFall;
    logic sda;
  } sswd_bus_t;

  typedef enum logic [5:0] {
    SL_IDLE = 6'h01,
    SL_ADDR = 6'h02,
    SL_WACK = 6'h04,
    SL_WRX  = 6'h08,
    SL_TX   = 6'h10,
    SL_RACK = 6'h20
  } sswd_slave_t;

endpackage

// >>> verilog/sswd_bus_detect.sv
// Pin synchroniser and START/STOP/edge detector for the two-wire bus
`timescale 1ns/1ps
module sswd_bus_detect
  import sswd_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  input  wire logic      clkEn,
  input  wire logic      sclIn,
  input  wire logic      sdaIn,
  output sswd_bus_t      busEv
);
  logic [1:0] sclSync_q, sclSync_d;
  logic [1:0] sdaSync_q, sdaSync_d;
  logic       sclOld_q,  sclOld_d;
  logic       sdaOld_q,  sdaOld_d;

  always_comb begin
    sclSync_d = {sclSync_q[0], sclIn};
    sdaSync_d = {sdaSync_q[0], sdaIn};
    sclOld_d  = sclSync_q[1];
    sdaOld_d  = sdaSync_q[1];
    busEv.start   = sclOld_q & sclSync_q[1] & sdaOld_q & ~sdaSync_q[1];
    busEv.stop    = sclOld_q & sclSync_q[1] & ~sdaOld_q & sdaSync_q[1];
    busEv.sclRise = ~sclOld_q & sclSync_q[1];
    busEv.sclFall = sclOld_q & ~sclSync_q[1];
    busEv.sda     = sdaSync_q[1];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclOld_q  <= 1'h1;
      sdaOld_q  <= 1'h1;
    end else if (clkEn) begin
      sclSync_q <= sclSync_d;
      sdaSync_q <= sdaSync_d;
      sclOld_q  <= sclOld_d;
      sdaOld_q  <= sdaOld_d;
    end
  end
endmodule

// >>> tb/sswd_sup_props.sv
// Checker for the supply supervisor and watchdog ports
`timescale 1ns/1ps
module sswd_sup_props
  import sswd_pkg::*;
#(
  parameter int RESET_TICKS_P = RESET_TICKS
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic oscTick,
  input sswd_cmp_t cmpIn,
  input wire logic supplySwitchSelect,
  input wire logic sclIn,
  input wire logic reset_n,
  input wire logic onBackup,
  input wire logic sdaOe,
  input wire logic addrMatch,
  input wire logic busStop,
  input wire logic abortWrite
);
  logic [15:0] relCnt_q, relCnt_d;
  logic        supLow_q, supLow_d;
  // Ticks since main was last low or on backup; supply reset still pending
  always_comb begin
    relCnt_d = relCnt_q;
    if (cmpIn.mainBelowReset || onBackup) relCnt_d = 16'h0000;
    else if (oscTick && relCnt_q != 16'hFFFF) relCnt_d = relCnt_q + 16'h0001;
    supLow_d = cmpIn.mainBelowReset || (supLow_q && !reset_n);
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      relCnt_q <= 16'h0000;
      supLow_q <= 1'b1;
    end else begin
      relCnt_q <= relCnt_d;
      supLow_q <= supLow_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  bk_enter_a: assert property (
    $rose(onBackup) |-> $past(cmpIn.mainBelowBackupLo, 3)
      && ($past(supplySwitchSelect) || $past(cmpIn.mainBelowSwitchover, 3)))
    else $error("backup entered without its supply condition");
  bk_leave_a: assert property (
    $fell(onBackup) |-> $past(cmpIn.mainAboveBackupHi, 3)
      || (!$past(supplySwitchSelect) && $past(cmpIn.mainAboveSwitchHi, 3)))
    else $error("backup left without its supply condition");
  abort_bk_a: assert property (
    abortWrite |-> $past(onBackup)) else $error("write abort outside backup");
  uv_hold_a: assert property (
    cmpIn.mainBelowReset [*5] |-> !reset_n) else $error("reset high while main low");
  rel_delay_a: assert property (
    $rose(reset_n) |-> relCnt_q >= RESET_TICKS_P) else $error("reset released early");
  bk_reset_a: assert property (
    onBackup && supLow_q && !reset_n |=> !reset_n) else $error("reset released on backup");
  sup_noack_a: assert property (
    supLow_q && $past(supLow_q, 4) |-> !sdaOe) else $error("bus answered in supply reset");
  ack_match_a: assert property (
    $rose(sdaOe) |-> addrMatch) else $error("data line driven without address match");
  sda_stable_a: assert property (
    $changed(sdaOe) |-> !sclIn) else $error("data line changed with clock high");
  stop_seen_a: assert property (
    busStop |-> $past(sclIn, 3)) else $error("stop flagged with clock low");
endmodule

bind sswd_supervisor sswd_sup_props #(.RESET_TICKS_P(RESET_TICKS_P)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .oscTick(oscTick), .cmpIn(cmpIn),
  .supplySwitchSelect(supplySwitchSelect), .sclIn(sclIn), .reset_n(reset_n),
  .onBackup(onBackup), .sdaOe(sdaOe), .addrMatch(addrMatch), .busStop(busStop),
  .abortWrite(abortWrite));

// >>> tb/sswd_master.sv
// Two-wire bus master model driving the supervisor's serial pins
`timescale 1ns/1ps
module sswd_master (
  input  wire logic ref_clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaDrv
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // Third of a bit, long enough for the pin synchronisers
  task automatic half;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic start;
    half;
    sdaDrv = 1'b1;
    half;
    scl = 1'b1;
    half;
    sdaDrv = 1'b0;
    half;
    scl = 1'b0;
  endtask
  task automatic stop;
    half;
    sdaDrv = 1'b0;
    half;
    scl = 1'b1;
    half;
    sdaDrv = 1'b1;
    half;
  endtask
  task automatic bitx(input logic b, output logic s);
    half;
    sdaDrv = b;
    half;
    scl = 1'b1;
    half;
    s = sdaLine;
    scl = 1'b0;
  endtask
  // Sends d (all ones to listen), then ackBit; ack is the line level seen
  task automatic xfer(input logic [7:0] d, input logic ackBit, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ackBit, ack);
  endtask
endmodule

// >>> tb/supply_supervisor_watchdog_bench.sv
// Self-checking bench for the supply supervisor and watchdog
`timescale 1ns/1ps
module supply_supervisor_watchdog_bench;
  import sswd_pkg::*;
  logic       ref_clk, scl, sdaDrv, ack, sdaOut, readReq, busStop, abortWr;
  logic       reset_n, onBackup, sdaOe, rxValid, addrMatch, ctrlSel;
  logic       rst_n = 1'b0, sel = 1'b0, wdHi = 1'b1, wdLo = 1'b1, nvBusy = 1'b0, oscTick = 1'b0;
  logic       en = 1'b1;
  logic [7:0] txData = 8'h00, rxData, q, d, w;
  sswd_cmp_t  cmp = 5'h0A;
  int         n_fail = 0, n_compared = 0, tickDiv = 128, cnt = 0, nStop = 0, nRd = 0, n;
  logic [7:0] expQ[$];
  logic [5:0] sup[8] = '{6'h10, 6'h14, 6'h02, 6'h14, 6'h08, 6'h30, 6'h22, 6'h28};
  logic [7:0] supExp = 8'h6A;
  logic [6:0] wd[4] = '{7'h6A, 7'h2A, 7'h0A, 7'h54};
  wire        sdaLine = sdaDrv & (sdaOe ? sdaOut : 1'b1);

  sswd_supervisor #(.RESET_TICKS_P(8)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(en), .oscTick(oscTick), .cmpIn(cmp),
    .supplySwitchSelect(sel), .wdogPeriodHi(wdHi), .wdogPeriodLo(wdLo), .nvWriteBusy(nvBusy),
    .sclIn(scl), .sdaIn(sdaLine), .txData(txData), .reset_n(reset_n), .onBackup(onBackup),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .rxData(rxData), .rxValid(rxValid), .addrMatch(addrMatch),
    .ctrlSelect(ctrlSel), .readReq(readReq), .busStop(busStop), .abortWrite(abortWr));
  sswd_master u_m (.ref_clk(ref_clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic waitRst(input logic v, input int max);
    for (int i = 0; i < max && reset_n !== v; i++) cyc(1);
    chk(8'(reset_n), 8'(v));
  endtask
  task automatic addr(input logic [7:0] a, input logic expAck);
    u_m.start;
    u_m.xfer(a, 1'b1, q, ack);
    chk(8'(ack), 8'(!expAck));
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    cnt <= (cnt + 1) % tickDiv;
    oscTick <= (cnt == 0);
  end
  always @(posedge ref_clk) begin
    if (rxValid === 1'b1) chk(rxData, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);
    if (busStop === 1'b1) nStop++;
    if (readReq === 1'b1) nRd++;
  end
  initial begin
    cyc(100000);
    n_fail++;
    report_and_stop;
  end

  initial begin
    void'($urandom(801));
    cyc(8);
    rst_n = 1'b1;
    cyc(200);
    chk(8'(reset_n), 8'h00);
    addr(8'hAE, 1'b0);
    u_m.stop;
    waitRst(1'b1, 1200);
    tickDiv = 4;
    nStop = 0;
    for (int k = 0; k < 2; k++) begin
      addr(k ? 8'hDE : 8'hAE, 1'b1);
      chk(8'({addrMatch, ctrlSel}), 8'(2 + k));
      repeat (2) begin
        d = 8'($urandom);
        expQ.push_back(d);
        u_m.xfer(d, 1'b1, q, ack);
        chk(8'(ack), 8'h00);
      end
      u_m.stop;
    end
    chk(8'(nStop), 8'h02);
    w = 8'($urandom);
    if (w[7:1] == ARRAY_ID || w[7:1] == CTRL_ID) w[7] = !w[7];
    for (int k = 0; k < 2; k++) begin
      addr(k ? 8'hAC : w & 8'hFE, 1'b0);
      u_m.xfer(8'($urandom), 1'b1, q, ack);
      chk(8'(ack), 8'h01);
      chk(8'(addrMatch), 8'h00);
      u_m.stop;
    end
    d = 8'($urandom);
    txData = d;
    nRd = 0;
    addr(8'hAF, 1'b1);
    for (int j = 0; j < 3; j++) begin
      w = 8'($urandom);
      u_m.xfer(8'hFF, j == 2, q, ack);
      txData = w;
      chk(q, d);
      d = w;
    end
    u_m.stop;
    chk(8'(nRd), 8'h03);
    nvBusy = 1'b1;
    for (int i = 0; i < 8; i++) begin
      sel = sup[i][5];
      cyc(1);
      cmp = sup[i][4:0];
      cyc(6);
      chk(8'(onBackup), 8'(supExp[i]));
    end
    cmp = 5'h11;
    cyc(8);
    chk(8'({onBackup, reset_n, abortWr}), 8'h05);
    cmp = 5'h10;
    cyc(100);
    chk(8'(reset_n), 8'h00);
    cmp = 5'h0A;
    waitRst(1'b1, 120);
    sel = 1'b0;
    cmp = 5'h0B;
    cyc(8);
    chk(8'({onBackup, reset_n, abortWr}), 8'h00);
    addr(8'hAE, 1'b0);
    u_m.stop;
    cmp = 5'h0A;
    // Frozen clock enable must hold the release count
    en = 1'b0;
    cyc(40);
    en = 1'b1;
    cyc(20);
    chk(8'(reset_n), 8'h00);
    waitRst(1'b1, 60);
    tickDiv = 1;
    {wdHi, wdLo} = WDOG_SHORT;
    u_m.start;
    u_m.stop;
    cyc(6000);
    u_m.start;
    u_m.stop;
    cyc(8000);
    chk(8'(reset_n), 8'h01);
    waitRst(1'b0, 400);
    tickDiv = 16;
    u_m.start;
    u_m.stop;
    for (n = 64; n < 400 && reset_n !== 1'b1; n++) cyc(1);
    chk(8'(n >= 100 && n <= 144), 8'h01);
    tickDiv = 1;
    for (int i = 0; i < 4; i++) begin
      {wdHi, wdLo, cmp} = wd[i];
      cyc(9000);
      chk(8'(reset_n), 8'h01);
    end
    cmp = 5'h0A;
    cyc(10);
    chk(8'(expQ.size()), 8'h00);
    report_and_stop;
  end
endmodule
